// ==== verilog/dmt_deadman_timer_control.sv ====
`include "dmt_consts.svh"

module dmt_deadman_timer_control (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [`DMT_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`DMT_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic configTimerEnable,
  input wire logic timerResetEvent,
  output logic timerEnable,
  output logic counterClear,
  output logic irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Register code 0..5, 7 for an unmapped word
  function automatic logic [2:0] regIdx(
    input logic [`DMT_ADDR_W-1:0] a
  );
    logic [`DMT_ADDR_W-1:0] w;
    w = {a[`DMT_ADDR_W-1:2], 2'h0};
    case (w)
      `DMT_OFF_CONTROL: regIdx = 3'h0;
      `DMT_OFF_PRECLEAR: regIdx = 3'h1;
      `DMT_OFF_SECOND: regIdx = 3'h2;
      `DMT_OFF_STATUS: regIdx = 3'h3;
      `DMT_OFF_MASK: regIdx = 3'h4;
      `DMT_OFF_STATE: regIdx = 3'h5;
      default: regIdx = 3'h7;
    endcase
  endfunction : regIdx

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dmt_pkg::dmt_state_t s_q;
  dmt_pkg::dmt_state_t s_d;

  logic wrDo;
  logic [2:0] wrIdx;
  logic [2:0] rdIdx;
  logic keyWr;
  logic [7:0] keyVal;
  logic secWr;
  logic secGood;
  logic armed;
  logic [`DMT_ST_W-1:0] evt;
  logic [`DMT_ST_W-1:0] w1c;

  // Handshakes stay combinational off the registered state
  assign awready = (s_q.wrState == dmt_pkg::DMT_WR_COLLECT) &&
                   !s_q.awHeld;
  assign wready = (s_q.wrState == dmt_pkg::DMT_WR_COLLECT) &&
                  !s_q.wHeld;
  assign bvalid = (s_q.wrState == dmt_pkg::DMT_WR_RESP);
  assign bresp = s_q.bResp;
  // One read in flight; a new address waits for rready
  assign arready = !s_q.rValid;
  assign rvalid = s_q.rValid;
  assign rdata = s_q.rData;
  assign rresp = s_q.rResp;
  assign timerEnable = s_q.timerEn;
  assign counterClear = s_q.counterClear;
  assign irq = |(s_q.status & s_q.mask);

  // ----------------------------------------------------------------
  // Write decode and key checks
  // ----------------------------------------------------------------

  // A write executes once both address and data are held
  assign wrDo = (s_q.wrState == dmt_pkg::DMT_WR_COLLECT) &&
                s_q.awHeld && s_q.wHeld;
  assign wrIdx = regIdx(s_q.awAddr);
  assign rdIdx = regIdx(araddr);
  assign armed = (s_q.keyField == `DMT_FIRST_KEY);
  // Keys live in byte lanes, so a lane left out is no write
  assign keyWr = wrDo && (wrIdx == 3'h1) && s_q.wStrb[1];
  assign keyVal = s_q.wData[`DMT_KEY_LSB+7:`DMT_KEY_LSB];
  assign secWr = wrDo && (wrIdx == 3'h2) && s_q.wStrb[0];
  assign secGood = secWr && armed &&
                   (s_q.wData[7:0] == `DMT_SECOND_KEY);

  // Sticky events: bad first key, bad second key, count cleared
  always_comb begin
    evt = '0;
    evt[`DMT_ST_BAD_FIRST_KEY_FLAG] = keyWr && (keyVal != `DMT_FIRST_KEY);
    evt[`DMT_ST_BAD2] = secWr && !secGood;
    evt[`DMT_ST_CLR] = secGood;
    w1c = '0;
    if (wrDo && (wrIdx == 3'h3) && s_q.wStrb[0]) begin
      w1c = s_q.wData[`DMT_ST_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.counterClear = 1'b0;
    // Config strap comes from outside this clock domain
    s_d.cfgMeta = configTimerEnable;
    s_d.cfgSync = s_q.cfgMeta;
    // Config set forces the timer on, else software decides
    s_d.timerEn = s_q.cfgSync | s_q.swEnable;

    // Capture address and data in either order
    if (awvalid && awready) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      s_d.wHeld = 1'b1;
      s_d.wData = wdata;
      s_d.wStrb = wstrb;
    end

    unique case (s_q.wrState)
      dmt_pkg::DMT_WR_COLLECT: begin
        if (wrDo) begin
          s_d.awHeld = 1'b0;
          s_d.wHeld = 1'b0;
          s_d.wrState = dmt_pkg::DMT_WR_RESP;
          s_d.bResp = (wrIdx == 3'h7) ? `DMT_RESP_SLVERR :
                      `DMT_RESP_OKAY;
          if (wrIdx == 3'h0 && s_q.wStrb[1]) begin
            s_d.swEnable = s_q.wData[`DMT_ENABLE_BIT];
          end
          if (wrIdx == 3'h4 && s_q.wStrb[0]) begin
            s_d.mask = s_q.wData[`DMT_ST_W-1:0];
          end
        end
      end
      dmt_pkg::DMT_WR_RESP: begin
        if (bready) begin
          s_d.wrState = dmt_pkg::DMT_WR_COLLECT;
        end
      end
      default: begin
        s_d.wrState = dmt_pkg::DMT_WR_COLLECT;
      end
    endcase

    // Key field keeps what was written; only 0x40 arms
    if (keyWr) begin
      s_d.keyField = keyVal;
    end
    // Completed sequence disarms and restarts the count
    if (secGood) begin
      s_d.keyField = `DMT_RST_KEY;
      s_d.counterClear = 1'b1;
    end
    // Timer reset wins over a key written in the same cycle
    if (timerResetEvent) begin
      s_d.keyField = `DMT_RST_KEY;
    end

    // Set wins over a write-one-to-clear in the same cycle
    s_d.status = (s_q.status & ~w1c) | evt;

    // Read channel
    if (s_q.rValid && rready) begin
      s_d.rValid = 1'b0;
    end
    if (arvalid && arready) begin
      s_d.rValid = 1'b1;
      s_d.rResp = `DMT_RESP_OKAY;
      s_d.rData = '0;
      case (rdIdx)
        3'h0: s_d.rData[`DMT_ENABLE_BIT] = s_q.swEnable;
        3'h1: begin
          s_d.rData[`DMT_KEY_LSB+7:`DMT_KEY_LSB] = s_q.keyField;
        end
        3'h3: s_d.rData[`DMT_ST_W-1:0] = s_q.status;
        3'h4: s_d.rData[`DMT_ST_W-1:0] = s_q.mask;
        3'h5: begin
          s_d.rData[2:0] = {s_q.cfgSync, armed, s_q.timerEn};
        end
        3'h7: s_d.rResp = `DMT_RESP_SLVERR;
        // Second key reads as zero
        default: s_d.rData = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Synchronous reset; write channel starts collecting
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.wrState <= dmt_pkg::DMT_WR_COLLECT;
      s_q.keyField <= `DMT_RST_KEY;
      s_q.status <= `DMT_RST_STATUS;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dmtCb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Written enable bit reaches the timer output two edges on
  AST_ENABLE_BIT: assert property (
    wrDo && wrIdx == 3'h0 && s_q.wStrb[1] && !s_q.cfgSync
    |=> ##1 (timerEnable == $past(s_q.wData[`DMT_ENABLE_BIT], 2))
  ) else $error("enable bit write not applied");

  // Config strap forces the timer on regardless of software
  AST_CFG_GOVERNS: assert property (
    s_q.cfgSync |=> timerEnable
  ) else $error("config enable did not force timer on");

  AST_SW_OFF: assert property (
    !s_q.cfgSync && !s_q.swEnable |=> !timerEnable
  ) else $error("timer on with both enables clear");

  AST_FIRST_KEY: assert property (
    keyWr && keyVal == `DMT_FIRST_KEY && !timerResetEvent
    |=> armed && !$rose(s_q.status[`DMT_ST_BAD_FIRST_KEY_FLAG])
  ) else $error("first key did not arm");

  AST_BAD_FIRST: assert property (
    keyWr && keyVal != `DMT_FIRST_KEY
    |=> s_q.status[`DMT_ST_BAD_FIRST_KEY_FLAG] && !armed
  ) else $error("wrong first key not flagged");

  AST_RESET_CLEARS: assert property (
    timerResetEvent |=> s_q.keyField == `DMT_RST_KEY
  ) else $error("timer reset left key field set");

  AST_SECOND_CLEARS: assert property (
    secWr && armed && s_q.wData[7:0] == `DMT_SECOND_KEY
    |=> s_q.keyField == `DMT_RST_KEY && counterClear
        ##1 !counterClear
  ) else $error("good second key did not clear");

  AST_CLEAR_NEEDS_SEQ: assert property (
    $rose(counterClear) |-> $past(armed) && $past(secWr)
        && s_q.status[`DMT_ST_CLR]
  ) else $error("count cleared without full sequence");

  AST_BAD_SECOND: assert property (
    secWr && !armed |=> !counterClear && s_q.status[`DMT_ST_BAD2]
  ) else $error("unarmed second key restarted count");

  // ----------------------------------------------------------------
  // Checks on state that must hold still and on readback
  // ----------------------------------------------------------------

  // Enable bit moves only on a control write with the upper lane
  AST_ENABLE_HOLDS: assert property (
    !(wrDo && wrIdx == 3'h0 && s_q.wStrb[1]) |=> $stable(s_q.swEnable)
  ) else $error("enable bit moved without a write");

  // Control reads back the enable bit alone, other bits zero
  AST_ENABLE_READ: assert property (
    arvalid && arready && rdIdx == 3'h0
    |=> rdata == {16'h0000, $past(s_q.swEnable), 15'h0000}
  ) else $error("control readback wrong");

  // With the strap clear the timer follows the software bit
  AST_SW_FOLLOWS: assert property (
    !s_q.cfgSync |=> timerEnable == $past(s_q.swEnable)
  ) else $error("timer did not follow software enable");

  // Armed state is reached only through a first key write
  AST_ARM_NEEDS_KEY: assert property (
    $rose(armed) |-> $past(keyWr) && $past(keyVal) == `DMT_FIRST_KEY
  ) else $error("armed without a first key write");

  // Key field moves only on a key write, a good second key or a reset
  AST_KEY_HOLDS: assert property (
    !keyWr && !secGood && !timerResetEvent |=> $stable(s_q.keyField)
  ) else $error("key field moved on its own");

  // Preclear reads the key field in the upper byte, the rest zero
  AST_KEY_READ: assert property (
    arvalid && arready && rdIdx == 3'h1
    |=> rdata == {16'h0000, $past(s_q.keyField), 8'h00}
  ) else $error("preclear readback wrong");

  // Software must see every wrong key, so the flag waits for its clear
  AST_BAD_FIRST_KEY_FLAG_STICKY: assert property (
    s_q.status[`DMT_ST_BAD_FIRST_KEY_FLAG] && !w1c[`DMT_ST_BAD_FIRST_KEY_FLAG]
    |=> s_q.status[`DMT_ST_BAD_FIRST_KEY_FLAG]
  ) else $error("bad first key flag dropped by itself");

  // Field disarms only through a key write, a good second key or reset
  AST_DISARM_CAUSE: assert property (
    $fell(armed)
    |-> $past(keyWr) || $past(secGood) || $past(timerResetEvent)
  ) else $error("key field disarmed with no cause");

  // Restart pulse stands for exactly one cycle
  AST_PULSE_ONE: assert property (
    counterClear |=> !counterClear
  ) else $error("restart pulse longer than one cycle");

  // A first key write alone never restarts the count
  AST_KEY_NO_RESTART: assert property (
    keyWr |=> !counterClear
  ) else $error("first key write restarted count");

  // Bad second key and count-cleared flags are sticky as well
  AST_BAD2_STICKY: assert property (
    s_q.status[`DMT_ST_BAD2] && !w1c[`DMT_ST_BAD2]
    |=> s_q.status[`DMT_ST_BAD2]
  ) else $error("bad second key flag dropped by itself");

  AST_CLR_STICKY: assert property (
    s_q.status[`DMT_ST_CLR] && !w1c[`DMT_ST_CLR]
    |=> s_q.status[`DMT_ST_CLR]
  ) else $error("count cleared flag dropped by itself");

endmodule : dmt_deadman_timer_control

// ==== verilog/dmt_consts.svh ====
`ifndef DMT_CONSTS_SVH
`define DMT_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the AXI4-Lite slave
// ----------------------------------------------------------------
`define DMT_ADDR_W 8
`define DMT_OFF_CONTROL 8'h00
`define DMT_OFF_PRECLEAR 8'h04
`define DMT_OFF_SECOND 8'h08
`define DMT_OFF_STATUS 8'h0C
`define DMT_OFF_MASK 8'h10
`define DMT_OFF_STATE 8'h14

// ----------------------------------------------------------------
// Field positions and key values
// ----------------------------------------------------------------
`define DMT_ENABLE_BIT 15
`define DMT_KEY_LSB 8
`define DMT_FIRST_KEY 8'h40
// Second-step key value is arbitrary here
`define DMT_SECOND_KEY 8'h08
`define DMT_ST_BAD_FIRST_KEY_FLAG 0
`define DMT_ST_BAD2 1
`define DMT_ST_CLR 2
`define DMT_ST_W 3

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define DMT_RST_KEY 8'h00
`define DMT_RST_STATUS 3'h0
`define DMT_RESP_OKAY 2'h0
`define DMT_RESP_SLVERR 2'h2

`endif

// ==== verilog/dmt_pkg.sv ====
`include "dmt_consts.svh"

package dmt_pkg;

  // ----------------------------------------------------------------
  // Write channel sequencing, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DMT_WR_COLLECT = 2'h1,
    DMT_WR_RESP = 2'h2
  } dmt_wr_state_t;

  // ----------------------------------------------------------------
  // Whole state of the control block
  // ----------------------------------------------------------------
  typedef struct packed {
    dmt_wr_state_t wrState;
    logic awHeld;
    logic [`DMT_ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic swEnable;
    logic [7:0] keyField;
    logic [`DMT_ST_W-1:0] status;
    logic [`DMT_ST_W-1:0] mask;
    logic cfgMeta;
    logic cfgSync;
    logic timerEn;
    logic counterClear;
  } dmt_state_t;

endpackage : dmt_pkg

// ==== testbench/dmt_deadman_timer_control_tb_top.sv ====
`include "dmt_consts.svh"

module dmt_deadman_timer_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL = `DMT_OFF_CONTROL;
  localparam logic [7:0] PRE = `DMT_OFF_PRECLEAR;
  localparam logic [7:0] SEC = `DMT_OFF_SECOND;
  localparam logic [7:0] STA = `DMT_OFF_STATUS;
  localparam logic [7:0] MSK = `DMT_OFF_MASK;
  localparam logic [7:0] STT = `DMT_OFF_STATE;
  localparam logic [1:0] OK = `DMT_RESP_OKAY;
  localparam logic [31:0] KEY2 = {24'h0, `DMT_SECOND_KEY};
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic cfgEn = 1'h0, resetEvent = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic timerEnable, counterClear, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] badKeys [4] = '{8'h00, 8'h41, 8'hBF, 8'hFF};
  int nErrors = 0, testsRun = 0, clrCount = 0;

  // 25 ns period
  always #12.5 core_clk = ~core_clk;

  // Counts restart pulses seen on the output
  always @(posedge core_clk) begin
    if (counterClear === 1'h1) begin
      clrCount <= clrCount + 1;
    end
  end

  dmt_deadman_timer_control uut (
    .core_clk(core_clk), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .configTimerEnable(cfgEn), .timerResetEvent(resetEvent),
    .timerEnable(timerEnable), .counterClear(counterClear), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Ready is looked at mid-cycle, where it is settled for the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] expR);
    logic ta, tw;
    logic ha = 1'h0;
    logic hw = 1'h0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ha && hw)) begin
      @(negedge core_clk);
      ta = awvalid && awready === 1'h1;
      tw = wvalid && wready === 1'h1;
      @(posedge core_clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      ha = ha | ta;
      hw = hw | tw;
    end
    do @(negedge core_clk); while (bvalid !== 1'h1);
    chk({30'h0, bresp}, {30'h0, expR}, "bresp");
    @(posedge core_clk);
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] expD,
                    input logic [1:0] expR);
    logic t;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge core_clk);
      t = arready === 1'h1;
      @(posedge core_clk);
    end while (!t);
    arvalid <= 1'h0;
    do @(negedge core_clk); while (rvalid !== 1'h1);
    chk(rdata, expD, "rdata");
    chk({30'h0, rresp}, {30'h0, expR}, "rresp");
    @(posedge core_clk);
    rready <= 1'h0;
  endtask : rd

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'h1;
    @(negedge core_clk);
    chk({29'h0, timerEnable, counterClear, irq}, 32'h0, "idle");
    rd(CTL, 32'h0, OK);
    rd(PRE, 32'h0, OK);
    wr(CTL, 32'h8000, 4'h1, OK);
    rd(CTL, 32'h0, OK);
    wr(CTL, 32'h8000, 4'h2, OK);
    repeat (2) @(negedge core_clk);
    chk({31'h0, timerEnable}, 32'h1, "enable");
    rd(STT, 32'h1, OK);
    wr(CTL, 32'h0, 4'h2, OK);
    repeat (2) @(negedge core_clk);
    chk({31'h0, timerEnable}, 32'h0, "disable");
    $display("test enable done");
    // Config enable takes three edges through its synchroniser
    @(posedge core_clk);
    cfgEn <= 1'h1;
    repeat (4) @(negedge core_clk);
    chk({31'h0, timerEnable}, 32'h1, "cfg on");
    wr(CTL, 32'h8000, 4'h2, OK);
    wr(CTL, 32'h0, 4'h2, OK);
    repeat (2) @(negedge core_clk);
    chk({31'h0, timerEnable}, 32'h1, "cfg wins");
    rd(STT, 32'h5, OK);
    @(posedge core_clk);
    cfgEn <= 1'h0;
    repeat (4) @(negedge core_clk);
    chk({31'h0, timerEnable}, 32'h0, "cfg off");
    $display("test config done");
    wr(MSK, 32'h7, 4'h1, OK);
    wr(PRE, 32'h4000, 4'h2, OK);
    rd(PRE, 32'h4000, OK);
    rd(STA, 32'h0, OK);
    rd(STT, 32'h2, OK);
    wr(SEC, KEY2, 4'h1, OK);
    @(negedge core_clk);
    chk(clrCount, 32'h1, "restart");
    rd(PRE, 32'h0, OK);
    rd(STA, 32'h4, OK);
    wr(STA, 32'h4, 4'h1, OK);
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0, "irq clear");
    $display("test sequence done");
    // Every wrong first key flags and leaves the field disarmed
    foreach (badKeys[i]) begin
      wr(PRE, {16'h0, badKeys[i], 8'h0}, 4'h2, OK);
      rd(PRE, {16'h0, badKeys[i], 8'h0}, OK);
      rd(STA, 32'h1, OK);
      @(negedge core_clk);
      chk({31'h0, irq}, 32'h1, "irq bad");
      wr(STA, 32'h1, 4'h1, OK);
    end
    wr(PRE, 32'h1100, 4'h2, OK);
    wr(MSK, 32'h6, 4'h1, OK);
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0, "masked");
    wr(STA, 32'h1, 4'h1, OK);
    wr(SEC, KEY2, 4'h1, OK);
    rd(STA, 32'h2, OK);
    wr(PRE, 32'h4000, 4'h2, OK);
    wr(SEC, KEY2 ^ 32'h1, 4'h1, OK);
    @(negedge core_clk);
    chk(clrCount, 32'h1, "no restart");
    $display("test bad keys done");
    wr(PRE, 32'h4000, 4'h2, OK);
    @(posedge core_clk);
    resetEvent <= 1'h1;
    @(posedge core_clk);
    resetEvent <= 1'h0;
    rd(PRE, 32'h0, OK);
    wr(SEC, KEY2, 4'h1, OK);
    @(negedge core_clk);
    chk(clrCount, 32'h1, "disarmed");
    $display("test reset event done");
    wr(8'h18, 32'hFFFF, 4'hF, `DMT_RESP_SLVERR);
    rd(8'h18, 32'h0, `DMT_RESP_SLVERR);
    $display("test unmapped done");
    complete_run();
  end

  // Whole run is a few hundred cycles; this leaves a wide margin
  initial begin
    repeat (5000) @(posedge core_clk);
    nErrors++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
endmodule : dmt_deadman_timer_control_tb_top
